// File: design/erc_regs.svh
// constants for the embedded memory block: widths, limits, reset values
// assumes inclusion by erc_pkg.sv, erc_block.sv and the bench files
//
// How it works
// (RULE_01) quad-port: two reads, two writes per cycle
// (RULE_02) true dual-port: any two port operations together
// (RULE_03) dual-port read+write; single-port never simultaneous
// (RULE_04) quad/true-dual shapes 256x16 down to 4096x1
// (RULE_05) dual/single ports may also be 128x32
// (RULE_06) port width ratios limited to 1..16
// (RULE_07) block splits into two 2048-bit halves
// (RULE_08) write strobe generated internally from the clock
// (RULE_09) read/write mode: write and read register groups
// (RULE_10) per-port read enable, write enable, clear
// (RULE_11) input/output mode: inputs versus data-out registers
// (RULE_12) every register clearable by clear or reset
// (RULE_13) at most two single-port memories per block
// (RULE_14) cam: 32x32 parallel compare, index and flag
// (RULE_15) don't-care stored bits never affect matching
// (RULE_16) encoded output gives matching word index
// (RULE_17) unencoded output gives 16 one-hot match lines
// (RULE_18) unencoded: 31-bit key, top bit picks bank
// (RULE_19) single-match: write two cycles, lookup one
// (RULE_20) multiple-match: 16 lines per cycle, two cycles
// (RULE_21) fast multiple-match: one cycle, 16 words
// (RULE_22) write two cycles, three with don't-cares
// (RULE_23) no match: flag low, address invalid
`ifndef ERC_REGS_SVH
`define ERC_REGS_SVH

`define ERC_ADDR_W 12
`define ERC_DATA_W 32
`define ERC_MEM_BITS 4096
`define ERC_LW_W 3
`define ERC_LW_MAX 3'h5
`define ERC_LW_MAX_QUAD 3'h4
`define ERC_RATIO_LOG_MAX 3'h4
`define ERC_CAM_WORDS 32
`define ERC_CAM_IDX_W 5
`define ERC_CAM_LINES 16
`define ERC_CAM_SEL_BIT 31
`define ERC_KEY31_MASK 32'h7fff_ffff
`define ERC_CARE_ALL 32'hffff_ffff
`define ERC_RST_WORD 32'h0000_0000

`endif

// File: design/erc_pkg.sv
// types for the embedded memory block: modes, states, the state record
// assumes erc_regs.svh is reachable on the include path
`include "erc_regs.svh"

package erc_pkg;

  typedef enum logic [2:0] {
    ERC_QUAD,
    ERC_TRUE_DUAL,
    ERC_DUAL,
    ERC_SINGLE,
    ERC_SPLIT
  } erc_ram_mode_t;

  typedef enum logic [1:0] {
    ERC_SINGLE_MATCH,
    ERC_MULTI_MATCH,
    ERC_FAST_MULTI
  } erc_cam_mode_t;

  typedef enum logic [1:0] {
    ERC_CAM_IDLE,
    ERC_CAM_WRITE,
    ERC_CAM_MASK,
    ERC_CAM_SCAN2
  } erc_cam_state_t;

  typedef struct packed {
    logic wr_en;
    logic [`ERC_ADDR_W-1:0] wr_addr;
    logic [`ERC_DATA_W-1:0] wr_data;
    logic rd_en;
    logic [`ERC_ADDR_W-1:0] rd_addr;
    logic [`ERC_DATA_W-1:0] dout;
  } erc_port_t;

  typedef struct packed {
    logic [`ERC_MEM_BITS-1:0] mem;
    erc_port_t [1:0] port;
    logic cfg_err;
    logic [`ERC_CAM_WORDS-1:0][`ERC_DATA_W-1:0] cam_word;
    logic [`ERC_CAM_WORDS-1:0][`ERC_DATA_W-1:0] cam_care;
    logic [`ERC_CAM_WORDS-1:0] cam_used;
    erc_cam_state_t cam_state;
    logic [`ERC_CAM_IDX_W-1:0] cw_addr;
    logic [`ERC_DATA_W-1:0] cw_data;
    logic [`ERC_DATA_W-1:0] cw_care;
    logic [`ERC_CAM_LINES-1:0] hi_hits;
    logic busy;
    logic valid;
    logic match;
    logic bank;
    logic [`ERC_CAM_IDX_W-1:0] addr;
    logic [`ERC_CAM_LINES-1:0] lines;
  } erc_state_t;

endpackage

// File: design/erc_block.sv
// embedded memory block: 4096-bit multi-mode ram plus 32x32 cam
// assumes all inputs come from fabric logic on ref_clk_in
`timescale 1ns/1ps
`default_nettype none
`include "erc_regs.svh"

module erc_block
  import erc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // ram configuration
  input wire erc_ram_mode_t ram_mode_in,
  input wire logic io_clock_mode_in,
  input wire logic [1:0][`ERC_LW_W-1:0] wr_width_in,
  input wire logic [1:0][`ERC_LW_W-1:0] rd_width_in,
  // ram ports, index 0 is port a, index 1 port b
  input wire logic [1:0] wr_ce_in,
  input wire logic [1:0] rd_ce_in,
  input wire logic [1:0] clear_in,
  input wire logic [1:0] wr_en_in,
  input wire logic [1:0][`ERC_ADDR_W-1:0] wr_addr_in,
  input wire logic [1:0][`ERC_DATA_W-1:0] wr_data_in,
  input wire logic [1:0] read_strobe_in,
  input wire logic [1:0][`ERC_ADDR_W-1:0] rd_addr_in,
  // ram results
  output logic [1:0][`ERC_DATA_W-1:0] rd_data_out,
  output logic config_error_out,
  // cam control
  input wire erc_cam_mode_t cam_mode_in,
  input wire logic cam_unencoded_in,
  input wire logic cam_wr_in,
  input wire logic [`ERC_CAM_IDX_W-1:0] cam_wr_addr_in,
  input wire logic [`ERC_DATA_W-1:0] cam_wr_data_in,
  input wire logic [`ERC_DATA_W-1:0] cam_wr_care_in,
  input wire logic cam_lookup_in,
  input wire logic [`ERC_DATA_W-1:0] cam_key_in,
  // cam results
  output logic cam_busy_out,
  output logic cam_valid_out,
  output logic cam_match_out,
  output logic [`ERC_CAM_IDX_W-1:0] cam_addr_out,
  output logic [`ERC_CAM_LINES-1:0] cam_lines_out,
  output logic cam_bank_out
);

  erc_state_t s;
  erc_state_t n;
  logic cfg_bad;
  logic split;
  logic [1:0] wr_ok;
  logic [1:0] rd_ok;
  logic [`ERC_LW_W-1:0] lw_max;
  logic [`ERC_LW_W-1:0] lw_min;
  logic [`ERC_ADDR_W-1:0] ba;
  logic [`ERC_DATA_W-1:0] keep;
  logic [`ERC_CAM_WORDS-1:0] hits;
  logic [`ERC_CAM_LINES-1:0] bank_lines;
  logic sel;
  logic [`ERC_CAM_IDX_W:0] first_hit;
  logic [`ERC_CAM_IDX_W:0] bank_first;
  logic width_big;
  logic ratio_big;
  logic quad_wide;

  // bits per word for a log2 width code
  function automatic logic [5:0] erc_bits(input logic [`ERC_LW_W-1:0] lw);
    return 6'(6'h01 << lw);
  endfunction

  // word address to bit address, folded into a half when split
  function automatic logic [`ERC_ADDR_W-1:0] erc_bit_addr(
    input logic [`ERC_ADDR_W-1:0] a,
    input logic [`ERC_LW_W-1:0] lw,
    input logic half_mode,
    input logic half
  );
    logic [`ERC_ADDR_W-1:0] b;
    b = `ERC_ADDR_W'(a << lw);
    if (half_mode) begin
      b = {half, b[`ERC_ADDR_W-2:0]};
    end
    return b;
  endfunction

  // lowest matching index with a found flag
  function automatic logic [`ERC_CAM_IDX_W:0] erc_first(input logic [`ERC_CAM_WORDS-1:0] v);
    logic [`ERC_CAM_IDX_W:0] r;
    r = '0;
    for (int i = `ERC_CAM_WORDS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, `ERC_CAM_IDX_W'(i)};
      end
    end
    return r;
  endfunction

  // next state: ram ports first, then the cam sequencer
  always_comb begin
    n = s;
    ba = '0;
    wr_ok = '0;
    rd_ok = '0;
    keep = '0;
    sel = 1'b0;
    hits = '0;
    bank_lines = '0;
    first_hit = '0;
    bank_first = '0;
    split = (ram_mode_in == ERC_SPLIT);

    // width legality across all four port sides
    lw_max = '0;
    lw_min = `ERC_LW_MAX;
    for (int p = 0; p < 2; p++) begin
      if (wr_width_in[p] > lw_max) begin
        lw_max = wr_width_in[p];
      end
      if (rd_width_in[p] > lw_max) begin
        lw_max = rd_width_in[p];
      end
      if (wr_width_in[p] < lw_min) begin
        lw_min = wr_width_in[p];
      end
      if (rd_width_in[p] < lw_min) begin
        lw_min = rd_width_in[p];
      end
    end
    width_big = (lw_max > `ERC_LW_MAX); // see RULE_04
    ratio_big = (`ERC_LW_W'(lw_max - lw_min) > `ERC_RATIO_LOG_MAX); // see RULE_06
    // only quad and true-dual shapes are held to 16 bits; dual, single and split may reach 32 (see RULE_05)
    quad_wide = ((ram_mode_in == ERC_QUAD) | (ram_mode_in == ERC_TRUE_DUAL))
      & (lw_max > `ERC_LW_MAX_QUAD); // see RULE_04
    cfg_bad = width_big | ratio_big | quad_wide;
    n.cfg_err = cfg_bad;

    // which operations each port may start in this mode
    for (int p = 0; p < 2; p++) begin
      wr_ok[p] = wr_en_in[p];
      rd_ok[p] = read_strobe_in[p];
      unique case (ram_mode_in)
        ERC_QUAD, ERC_SPLIT: begin
          // see RULE_01
          // see RULE_07
          rd_ok[p] = read_strobe_in[p];
        end
        ERC_TRUE_DUAL: begin
          // one operation per port, write first (see RULE_02)
          rd_ok[p] = read_strobe_in[p] & ~wr_en_in[p];
        end
        ERC_DUAL: begin
          // port a writes while port b reads (see RULE_03)
          wr_ok[p] = wr_en_in[p] & (p == 0);
          rd_ok[p] = read_strobe_in[p] & (p == 1);
        end
        ERC_SINGLE: begin
          // port a only, never both at once (see RULE_03)
          // see RULE_13
          wr_ok[p] = wr_en_in[p] & (p == 0);
          rd_ok[p] = read_strobe_in[p] & ~wr_en_in[p] & (p == 0);
        end
        default: begin
          // unused mode codes start nothing
          wr_ok[p] = 1'b0;
          rd_ok[p] = 1'b0;
        end
      endcase
    end

    // array access from registered inputs, port b writes last
    for (int p = 0; p < 2; p++) begin
      if (s.port[p].rd_en && rd_ce_in[p]) begin
        // data-out register on the read or output clock enable (see RULE_09)
        ba = erc_bit_addr(s.port[p].rd_addr, rd_width_in[p], split, 1'(p));
        for (int i = 0; i < `ERC_DATA_W; i++) begin
          n.port[p].dout[i] = (6'(i) < erc_bits(rd_width_in[p]))
            ? s.mem[`ERC_ADDR_W'(ba + `ERC_ADDR_W'(i))] : 1'b0;
        end
      end
    end
    for (int p = 0; p < 2; p++) begin
      if (s.port[p].wr_en) begin
        // internal write strobe from the registered enable (see RULE_08)
        ba = erc_bit_addr(s.port[p].wr_addr, wr_width_in[p], split, 1'(p));
        for (int i = 0; i < `ERC_DATA_W; i++) begin
          if (6'(i) < erc_bits(wr_width_in[p])) begin
            n.mem[`ERC_ADDR_W'(ba + `ERC_ADDR_W'(i))] = s.port[p].wr_data[i];
          end
        end
      end
    end

    // input registers per port and clocking mode
    for (int p = 0; p < 2; p++) begin
      n.port[p].wr_en = wr_ce_in[p] & wr_ok[p] & ~cfg_bad;
      if (wr_ce_in[p]) begin
        // write group on the write or input clock enable (see RULE_09)
        n.port[p].wr_addr = wr_addr_in[p];
        n.port[p].wr_data = wr_data_in[p];
      end
      if (io_clock_mode_in ? wr_ce_in[p] : rd_ce_in[p]) begin
        // read request joins the input group in io mode (see RULE_11)
        // reloaded on each such edge: a read waits for the output enable only while its strobe stands
        n.port[p].rd_en = rd_ok[p] & ~cfg_bad;
        n.port[p].rd_addr = rd_addr_in[p];
      end
      if (clear_in[p]) begin
        // per-port clear of every port register (see RULE_10)
        // see RULE_12
        n.port[p] = '0;
      end
    end

    // cam compare, bit 31 becomes bank select when unencoded in single-match mode
    sel = cam_key_in[`ERC_CAM_SEL_BIT];
    keep = (cam_unencoded_in && cam_mode_in == ERC_SINGLE_MATCH)
      ? `ERC_KEY31_MASK : `ERC_CARE_ALL; // see RULE_18
    for (int w = 0; w < `ERC_CAM_WORDS; w++) begin
      // masked bits drop out of the compare (see RULE_15)
      hits[w] = s.cam_used[w] & ~|((cam_key_in ^ s.cam_word[w]) & s.cam_care[w] & keep);
    end
    if (cam_mode_in == ERC_FAST_MULTI) begin
      // only sixteen words exist in fast mode (see RULE_21)
      hits[`ERC_CAM_WORDS-1:`ERC_CAM_LINES] = '0;
    end
    for (int i = 0; i < `ERC_CAM_LINES; i++) begin
      // odd words when select high, even words when low (see RULE_18)
      bank_lines[i] = hits[2 * i + int'(sel)];
    end
    first_hit = erc_first(hits);
    bank_first = erc_first({16'h0000, bank_lines});

    // cam sequencer: a write beats a lookup in the same cycle
    n.valid = 1'b0;
    unique case (s.cam_state)
      ERC_CAM_IDLE: begin
        if (cam_wr_in) begin
          if (!(cam_mode_in == ERC_FAST_MULTI && cam_wr_addr_in[`ERC_CAM_IDX_W-1])) begin
            n.cw_addr = cam_wr_addr_in;
            n.cw_data = cam_wr_data_in;
            n.cw_care = cam_wr_care_in;
            n.cam_state = ERC_CAM_WRITE;
          end
        end else if (cam_lookup_in) begin
          n.valid = 1'b1;
          n.bank = 1'b0;
          unique case (cam_mode_in)
            ERC_SINGLE_MATCH: begin
              // result one cycle after the key (see RULE_19)
              if (cam_unencoded_in) begin
                // see RULE_17
                n.lines = bank_lines;
                n.bank = sel;
                n.match = |bank_lines;
                // bank index back to the word number
                n.addr = n.match ? {bank_first[`ERC_CAM_IDX_W-2:0], sel} : '0;
              end else begin
                // see RULE_14
                // see RULE_16
                n.lines = hits[`ERC_CAM_LINES-1:0];
                n.match = |hits;
                n.addr = first_hit[`ERC_CAM_IDX_W-1:0];
              end
            end
            ERC_MULTI_MATCH: begin
              // low sixteen now, high sixteen next cycle (see RULE_20)
              n.lines = hits[`ERC_CAM_LINES-1:0];
              n.hi_hits = hits[`ERC_CAM_WORDS-1:`ERC_CAM_LINES];
              n.match = |hits;
              n.addr = first_hit[`ERC_CAM_IDX_W-1:0];
              n.cam_state = ERC_CAM_SCAN2;
            end
            ERC_FAST_MULTI: begin
              // all sixteen lines in a single cycle (see RULE_21)
              n.lines = hits[`ERC_CAM_LINES-1:0];
              n.match = |hits;
              n.addr = first_hit[`ERC_CAM_IDX_W-1:0];
            end
            default: begin
              n.valid = 1'b0;
            end
          endcase
          if (!n.match) begin
            // no hit leaves flag low and index zeroed (see RULE_23)
            n.addr = '0;
          end
        end
      end
      ERC_CAM_WRITE: begin
        // commit waits for the last write cycle; lookups are not taken until then
        if (s.cw_care != `ERC_CARE_ALL) begin
          // don't-care bits cost one more cycle (see RULE_22)
          n.cam_state = ERC_CAM_MASK;
        end else begin
          n.cam_word[s.cw_addr] = s.cw_data;
          n.cam_care[s.cw_addr] = s.cw_care;
          n.cam_used[s.cw_addr] = 1'b1;
          n.cam_state = ERC_CAM_IDLE;
        end
      end
      ERC_CAM_MASK: begin
        n.cam_word[s.cw_addr] = s.cw_data;
        n.cam_care[s.cw_addr] = s.cw_care;
        n.cam_used[s.cw_addr] = 1'b1;
        n.cam_state = ERC_CAM_IDLE;
      end
      ERC_CAM_SCAN2: begin
        // see RULE_20
        n.valid = 1'b1;
        n.bank = 1'b1;
        n.lines = s.hi_hits;
        n.cam_state = ERC_CAM_IDLE;
      end
    endcase
    // busy is taken from the next state, so it never lags the sequencer
    n.busy = (n.cam_state != ERC_CAM_IDLE);
  end

  // one register stage holds the whole state record
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      // chip-wide reset clears everything (see RULE_12)
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign rd_data_out[0] = s.port[0].dout;
  assign rd_data_out[1] = s.port[1].dout;
  assign config_error_out = s.cfg_err;
  assign cam_busy_out = s.busy;
  assign cam_valid_out = s.valid;
  assign cam_match_out = s.match;
  assign cam_addr_out = s.addr;
  assign cam_lines_out = s.lines;
  assign cam_bank_out = s.bank;

endmodule

`default_nettype wire

// File: tb/erc_block_assertions.sv
// concurrent checks on the cam handshake and read-port hold of erc_block
// assumes one clock, bound onto erc_block by the statement at the foot
`timescale 1ns/1ps
`default_nettype none
`include "erc_regs.svh"

module erc_block_assertions
  import erc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [1:0] rd_ce_in,
  input wire logic [1:0] clear_in,
  input wire logic [1:0][`ERC_DATA_W-1:0] rd_data_out,
  input wire erc_cam_mode_t cam_mode_in,
  input wire logic cam_wr_in,
  input wire logic [`ERC_CAM_IDX_W-1:0] cam_wr_addr_in,
  input wire logic [`ERC_DATA_W-1:0] cam_wr_care_in,
  input wire logic cam_lookup_in,
  input wire logic cam_busy_out,
  input wire logic cam_valid_out,
  input wire logic cam_match_out,
  input wire logic [`ERC_CAM_IDX_W-1:0] cam_addr_out,
  input wire logic cam_bank_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  wire wr_drop = cam_wr_in && !cam_busy_out && cam_mode_in == ERC_FAST_MULTI
    && cam_wr_addr_in[`ERC_CAM_IDX_W-1];
  wire idle_wr = cam_wr_in && !cam_busy_out && !wr_drop;
  wire look = cam_lookup_in && !cam_wr_in && !cam_busy_out;
  a_wr_busy: assert property (idle_wr |=> cam_busy_out)
    else $error("cam write did not raise busy");
  a_wr_two_cycles: assert property ((idle_wr && cam_wr_care_in == `ERC_CARE_ALL)
    |=> cam_busy_out ##1 !cam_busy_out) else $error("plain cam write not two cycles");
  a_wr_three_cycles: assert property ((idle_wr && cam_wr_care_in != `ERC_CARE_ALL)
    |=> cam_busy_out [*2] ##1 !cam_busy_out) else $error("masked cam write not three cycles");
  a_look_one: assert property ((look && cam_mode_in != ERC_MULTI_MATCH) |=> cam_valid_out)
    else $error("lookup result late");
  a_multi_two: assert property ((look && cam_mode_in == ERC_MULTI_MATCH)
    |=> cam_valid_out ##1 (cam_valid_out && cam_bank_out)) else $error("multi lookup second cycle missing");
  a_miss_addr: assert property ((cam_valid_out && !cam_match_out) |-> cam_addr_out == 5'h00)
    else $error("miss with nonzero address");
  a_valid_cause: assert property (cam_valid_out |-> $past(look) || $past(cam_busy_out))
    else $error("result without lookup");
  a_rd_hold: assert property ((rd_ce_in == 2'h0 && clear_in == 2'h0) |=> $stable(rd_data_out))
    else $error("read data moved without enable");
  a_fast_drop: assert property (wr_drop |=> !cam_busy_out)
    else $error("fast mode write above sixteen words taken");
endmodule

bind erc_block erc_block_assertions u_chk (.ref_clk_in, .reset_in, .rd_ce_in, .clear_in, .rd_data_out,
  .cam_mode_in, .cam_wr_in, .cam_wr_addr_in, .cam_wr_care_in, .cam_lookup_in, .cam_busy_out, .cam_valid_out,
  .cam_match_out, .cam_addr_out, .cam_bank_out);
`default_nettype wire

// File: tb/erc_fabric_model.sv
// fabric-side writer of cam words, prompt or slow by gap
// assumes the block samples on the rising edge; drives on the falling one
`timescale 1ns/1ps
`default_nettype none

module erc_fabric_model
  import erc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic cam_busy_in,
  output logic cam_wr_out,
  output logic [4:0] cam_wr_addr_out,
  output logic [31:0] cam_wr_data_out,
  output logic [31:0] cam_wr_care_out
);
  int gap = 0;
  initial begin
    cam_wr_out = 1'b0;
    cam_wr_addr_out = 5'h00;
    cam_wr_data_out = 32'h0;
    cam_wr_care_out = 32'h0;
  end
  // ok low when busy never clears
  task automatic put(input logic [4:0] a, input logic [31:0] d, c, output logic ok);
    int n;
    n = 0;
    repeat (gap + 1) @(negedge ref_clk_in);
    cam_wr_addr_out = a;
    cam_wr_data_out = d;
    cam_wr_care_out = c;
    cam_wr_out = 1'b1;
    @(negedge ref_clk_in);
    cam_wr_out = 1'b0;
    cam_wr_data_out = ~d;
    cam_wr_care_out = ~c;
    while (cam_busy_in && n < 8) begin
      @(negedge ref_clk_in);
      n++;
    end
    ok = !cam_busy_in;
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for erc_block: ram widths and modes, cam lookups
// assumes erc_pkg compiled first; inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
`include "erc_regs.svh"

module tb;
  import erc_pkg::*;
  typedef struct packed {logic [31:0] k; logic m; logic [4:0] a; logic [15:0] l;} erc_row_t;
  logic ref_clk_in = 1'b0, reset_in = 1'b1, io_clock_mode_in = 1'b0, ok;
  erc_ram_mode_t ram_mode_in = ERC_TRUE_DUAL;
  erc_cam_mode_t cam_mode_in = ERC_SINGLE_MATCH;
  logic [1:0][2:0] wr_width_in = 6'h1b, rd_width_in = 6'h1b;
  logic [1:0] wr_ce_in = 2'h3, rd_ce_in = 2'h3, clear_in = 2'h0, wr_en_in = 2'h0, read_strobe_in = 2'h0;
  logic [1:0][11:0] wr_addr_in = 24'h0, rd_addr_in = 24'h0;
  logic [1:0][31:0] wr_data_in = 64'h0, rd_data_out;
  logic config_error_out, cam_unencoded_in = 1'b0, cam_lookup_in = 1'b0, cam_wr_in;
  logic [31:0] cam_key_in = 32'h0, cam_wr_data_in, cam_wr_care_in;
  logic [4:0] cam_wr_addr_in, cam_addr_out;
  logic [15:0] cam_lines_out;
  logic cam_busy_out, cam_valid_out, cam_match_out, cam_bank_out;
  int mismatches = 0, total_checks = 0;
  erc_row_t rows [5] = '{'{32'h0000_00aa, 1'b1, 5'h03, 16'h0088}, '{32'hfa12_0000, 1'b1, 5'h0c, 16'h1000},
    '{32'h1234_56ff, 1'b1, 5'h14, 16'h0000}, '{32'h1234_57ff, 1'b0, 5'h00, 16'h0000},
    '{32'h0000_0000, 1'b0, 5'h00, 16'h0000}};

  always #5 ref_clk_in = ~ref_clk_in;

  erc_block DUT (.ref_clk_in, .reset_in, .ram_mode_in, .io_clock_mode_in, .wr_width_in, .rd_width_in,
    .wr_ce_in, .rd_ce_in, .clear_in, .wr_en_in, .wr_addr_in, .wr_data_in, .read_strobe_in, .rd_addr_in,
    .rd_data_out, .config_error_out, .cam_mode_in, .cam_unencoded_in, .cam_wr_in, .cam_wr_addr_in,
    .cam_wr_data_in, .cam_wr_care_in, .cam_lookup_in, .cam_key_in, .cam_busy_out, .cam_valid_out,
    .cam_match_out, .cam_addr_out, .cam_lines_out, .cam_bank_out);
  erc_fabric_model u_fab (.ref_clk_in, .cam_busy_in(cam_busy_out), .cam_wr_out(cam_wr_in),
    .cam_wr_addr_out(cam_wr_addr_in), .cam_wr_data_out(cam_wr_data_in), .cam_wr_care_out(cam_wr_care_in));

  task automatic tick;
    @(negedge ref_clk_in);
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cw(input logic [4:0] a, input logic [31:0] d, c);
    u_fab.put(a, d, c, ok);
    if (!ok) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic look(input erc_row_t r);
    tick();
    cam_key_in = r.k;
    cam_lookup_in = 1'b1;
    tick();
    cam_lookup_in = 1'b0;
    chk("valid", cam_valid_out, 32'h1);
    chk("match", cam_match_out, r.m);
    chk("addr", cam_addr_out, r.a);
    chk("lines", cam_lines_out, r.l);
  endtask
  task automatic ram(input logic [1:0] we, re);
    tick();
    wr_en_in = we;
    read_strobe_in = re;
    tick();
    wr_en_in = 2'h0;
    read_strobe_in = 2'h0;
    tick();
  endtask
  task automatic cfg(input erc_ram_mode_t md, input logic [5:0] w, r, input logic e);
    tick();
    ram_mode_in = md;
    wr_width_in = w;
    rd_width_in = r;
    tick();
    chk("cfg err", config_error_out, e);
  endtask

  initial begin
    repeat (12) tick();
    reset_in = 1'b0;
    tick();
    chk("reset rd", rd_data_out[0] | rd_data_out[1], 32'h0);
    chk("reset cam", {cam_busy_out, cam_valid_out, cam_match_out, cam_bank_out, cam_addr_out}, 32'h0);
    cw(5'h03, 32'h0000_00aa, `ERC_CARE_ALL);
    cw(5'h07, 32'h0000_00aa, `ERC_CARE_ALL);
    u_fab.gap = 2;
    cw(5'h0c, 32'hfa12_0000, `ERC_CARE_ALL);
    cw(5'h14, 32'h1234_5600, 32'hffff_ff00);
    u_fab.gap = 0;
    foreach (rows[i]) look(rows[i]);
    cam_mode_in = ERC_MULTI_MATCH;
    look(rows[2]);
    tick();
    chk("multi hi", {cam_valid_out, cam_bank_out, cam_lines_out}, 32'h3_0010);
    cam_mode_in = ERC_SINGLE_MATCH;
    cam_unencoded_in = 1'b1;
    look('{32'h8000_00aa, 1'b1, 5'h03, 16'h000a});
    look('{32'h7a12_0000, 1'b1, 5'h0c, 16'h0040});
    look('{32'h0000_00aa, 1'b0, 5'h00, 16'h0000});
    cam_unencoded_in = 1'b0;
    cam_mode_in = ERC_FAST_MULTI;
    cw(5'h19, 32'h0000_0bbb, `ERC_CARE_ALL);
    look('{32'h0000_0bbb, 1'b0, 5'h00, 16'h0000});
    look(rows[0]);
    wr_addr_in = {12'h006, 12'h005};
    wr_data_in = {32'h0000_00a5, 32'h0000_003c};
    ram(2'h3, 2'h0);
    rd_addr_in = {12'h006, 12'h005};
    ram(2'h0, 2'h3);
    chk("rd a", rd_data_out[0], 32'h0000_003c);
    chk("rd b", rd_data_out[1], 32'h0000_00a5);
    io_clock_mode_in = 1'b1;
    rd_width_in = 6'h24;
    rd_addr_in = {12'h002, 12'h003};
    rd_ce_in = 2'h0;
    tick();
    read_strobe_in = 2'h3;
    tick();
    tick();
    chk("io hold a", rd_data_out[0], 32'h0000_003c);
    rd_ce_in = 2'h3;
    read_strobe_in = 2'h0;
    tick();
    chk("io rd a", rd_data_out[0], 32'h0000_00a5);
    chk("io rd b", rd_data_out[1], 32'h0000_3c00);
    io_clock_mode_in = 1'b0;
    clear_in = 2'h1;
    tick();
    clear_in = 2'h0;
    chk("clear a", rd_data_out[0], 32'h0);
    chk("clear b", rd_data_out[1], 32'h0000_3c00);
    cfg(ERC_QUAD, 6'h2d, 6'h2d, 1'b1);
    cfg(ERC_DUAL, 6'h2d, 6'h2d, 1'b0);
    wr_addr_in = {12'h001, 12'h001};
    wr_data_in = {32'h0000_0000, 32'h89ab_cdef};
    ram(2'h1, 2'h0);
    ram(2'h2, 2'h0);
    rd_addr_in = {12'h001, 12'h001};
    ram(2'h0, 2'h2);
    chk("dual rd b", rd_data_out[1], 32'h89ab_cdef);
    chk("dual rd a", rd_data_out[0], 32'h0);
    cfg(ERC_DUAL, 6'h28, 6'h2d, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
